// file: ingress_pkg.sv
// shared constants for the completion and request stream ingress
package ingress_pkg;
  // stream geometry
  localparam int DATA_W     = 256;
  localparam int KEEP_W     = 8;
  localparam int READY_W    = 4;
  localparam int CC_SB_W    = 33;
  localparam int RQ_SB_W    = 62;
  localparam int PAR_W      = 32;
  localparam int CC_ABORT_BIT = 0;
  localparam int CC_PAR_LSB   = 1;
  // configured bus width codes
  localparam logic [1:0] WIDTH_64  = 2'h0;
  localparam logic [1:0] WIDTH_128 = 2'h1;
  localparam logic [1:0] WIDTH_256 = 2'h2;
  // keep lanes honoured per width
  localparam logic [7:0] KEEP_MASK_64  = 8'h03;
  localparam logic [7:0] KEEP_MASK_128 = 8'h0f;
  localparam logic [7:0] KEEP_MASK_256 = 8'hff;
  // parity lanes honoured per width
  localparam logic [31:0] PAR_MASK_64  = 32'h0000_00ff;
  localparam logic [31:0] PAR_MASK_128 = 32'h0000_ffff;
  localparam logic [31:0] PAR_MASK_256 = 32'hffff_ffff;
  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET      = 12'h000;
  localparam logic [11:0] STATUS_OFFSET    = 12'h004;
  localparam logic [11:0] ABORT_CNT_OFFSET = 12'h008;
  localparam logic [11:0] RQ_ABORT_OFFSET  = 12'h00c;
  // control field positions
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_PAR_EN    = 2;
  localparam int CTRL_ENDPOINT  = 3;
  // values after reset
  localparam logic [1:0]  WIDTH_RESET    = WIDTH_256;
  localparam logic        PAR_EN_RESET   = 1'b0;
  localparam logic        ENDPOINT_RESET = 1'b1;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic        HRESP_OKAY    = 1'b0;
endpackage

// file: byte_parity_check.sv
// per-byte odd parity checker for one stream beat
`timescale 1ns/10ps
module byte_parity_check
  import ingress_pkg::*;
(
  input  wire logic [DATA_W-1:0] data,
  input  wire logic [PAR_W-1:0]  parity,
  input  wire logic [1:0]        width_mode,
  output logic                   mismatch
);
  logic [PAR_W-1:0] bad_lane;
  logic [PAR_W-1:0] lane_mask;

  // a byte plus its parity bit must hold an odd count of ones
  genvar i;
  generate
    for (i = 0; i < PAR_W; i++)
    begin : g_lane
      assign bad_lane[i] = ~(^{data[8*i +: 8], parity[i]});
    end
  endgenerate

  // lanes above the configured width are ignored
  always_comb
  begin
    if (width_mode == WIDTH_64)
      lane_mask = PAR_MASK_64;
    else if (width_mode == WIDTH_128)
      lane_mask = PAR_MASK_128;
    else
      lane_mask = PAR_MASK_256;
  end

  assign mismatch = |(bad_lane & lane_mask);
endmodule

// file: stream_beat_stage.sv
// one ingress port: handshake, framing, sticky abort and output register
`timescale 1ns/10ps
module stream_beat_stage
  import ingress_pkg::*;
#(
  parameter int PW = DATA_W
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic [1:0]        width_mode,
  input  wire logic              in_valid,
  input  wire logic              in_last,
  input  wire logic [KEEP_W-1:0] in_keep,
  input  wire logic [PW-1:0]     in_payload,
  input  wire logic              in_abort,
  input  wire logic              in_bad,
  output logic [READY_W-1:0]     ready_out,
  output logic                   out_valid,
  output logic                   out_last,
  output logic [KEEP_W-1:0]      out_keep,
  output logic [PW-1:0]          out_payload,
  output logic                   out_nullify,
  input  wire logic              out_ready,
  output logic                   busy,
  output logic                   abort_end
);
  logic              ready_q;
  logic              beat;
  logic              abort_q;
  logic              bad_q;
  logic              out_valid_d;
  logic [KEEP_W-1:0] keep_mask;

  // a beat moves only when valid meets ready
  assign beat = in_valid & ready_q;

  // keep lanes past the configured width are dropped [R5]
  always_comb
  begin
    if (width_mode == WIDTH_64)
      keep_mask = KEEP_MASK_64;
    else if (width_mode == WIDTH_128)
      keep_mask = KEEP_MASK_128;
    else
      keep_mask = KEEP_MASK_256;
  end

  // abort and discard marks, sticky until the last beat
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      abort_q <= 1'b0;
      bad_q   <= 1'b0;
    end
    else if (beat)
    begin
      abort_q <= ~in_last & (abort_q | in_abort);
      bad_q   <= ~in_last & (bad_q | in_bad);
    end
  end

  // packet-in-progress and end-of-aborted-packet pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy      <= 1'b0;
      abort_end <= 1'b0;
    end
    else
    begin
      if (beat)
        busy <= ~in_last;
      abort_end <= beat & in_last & (abort_q | in_abort);
    end
  end

  // output register loads on a beat, empties when taken
  assign out_valid_d = beat | (out_valid & ~out_ready);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_valid   <= 1'b0;
      out_last    <= 1'b0;
      out_keep    <= '0;
      out_payload <= '0;
      out_nullify <= 1'b0;
    end
    else
    begin
      out_valid <= out_valid_d;
      if (beat)
      begin
        out_last    <= in_last;
        out_keep    <= in_keep & keep_mask;
        out_payload <= in_payload;
        out_nullify <= abort_q | in_abort | bad_q | in_bad;
      end
    end
  end

  // ready only while the output register will be free
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ready_q <= 1'b0;
    else
      ready_q <= ~out_valid_d;
  end

  assign ready_out = {READY_W{ready_q}}; // [R9]
endmodule

// file: pcie_cc_rq_stream_ingress.sv
// completion and request stream ingress with ahb-lite control registers
//
// Summary of operation
// R1: bus width selectable 64, 128 or 256
// R2: completion sideband 33 bits, valid with valid
// R3: user marks last beat of each packet
// R4: keep one bit per word, contiguous
// R5: ignore keep lanes above configured width
// R6: user holds valid through whole packet
// R7: beat moves only when valid meets ready
// R8: user holds beat while ready low
// R9: all four ready bits carry one value
// R10: completion abort flag nullifies the packet
// R11: abort stays sticky until packet end
// R12: abort sampled only while ready high
// R13: endpoint reports completion abort through aer
// R14: user drives odd parity per byte
// R15: parity mismatch discards, sticky internal error
// R16: parity ignored when checking disabled
// R17: request sideband 62 bits, valid with valid
// R18: ports run independently, split transactions
// R19: beat means ready and valid both high
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
module pcie_cc_rq_stream_ingress
(
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic                                hresp,
  output logic [31:0]                         hrdata,
  input  wire logic [ingress_pkg::DATA_W-1:0] cc_tdata,
  input  wire logic [ingress_pkg::CC_SB_W-1:0] completion_sideband,
  input  wire logic                           cc_tlast,
  input  wire logic [ingress_pkg::KEEP_W-1:0] cc_tkeep,
  input  wire logic                           cc_tvalid,
  output logic [ingress_pkg::READY_W-1:0]     completion_ready_out,
  input  wire logic [ingress_pkg::DATA_W-1:0] rq_tdata,
  input  wire logic [ingress_pkg::RQ_SB_W-1:0] request_sideband,
  input  wire logic                           rq_tlast,
  input  wire logic [ingress_pkg::KEEP_W-1:0] rq_tkeep,
  input  wire logic                           rq_tvalid,
  output logic [ingress_pkg::READY_W-1:0]     request_ready_out,
  output logic                                cc_out_valid,
  output logic                                cc_out_last,
  output logic [ingress_pkg::KEEP_W-1:0]      cc_out_keep,
  output logic [ingress_pkg::DATA_W-1:0]      cc_out_data,
  output logic                                cc_out_nullify,
  input  wire logic                           cc_out_ready,
  output logic                                rq_out_valid,
  output logic                                rq_out_last,
  output logic [ingress_pkg::KEEP_W-1:0]      rq_out_keep,
  output logic [ingress_pkg::DATA_W-1:0]      rq_out_data,
  output logic [ingress_pkg::RQ_SB_W-1:0]     rq_out_sideband,
  output logic                                rq_out_nullify,
  input  wire logic                           rq_out_ready,
  output logic                                aer_abort_report,
  output logic                                internal_error
);
  import ingress_pkg::*;

  localparam int RQ_PW = DATA_W + RQ_SB_W;

  logic [1:0]       width_q;
  logic             par_en_q;
  logic             endpoint_q;
  logic [15:0]      cc_abort_cnt_q;
  logic [15:0]      rq_abort_cnt_q;
  logic             wr_pend_q;
  logic [11:0]      wr_addr_q;
  logic             ahb_take;
  logic [31:0]      rd_value;
  logic             par_mismatch;
  logic             cc_bad;
  logic             cc_beat;
  logic             cc_busy;
  logic             rq_busy;
  logic             cc_abort_end;
  logic             rq_abort_end;
  logic [RQ_PW-1:0] rq_out_payload;

  // ---------------- ahb-lite slave ----------------

  // address phase of a word transfer to this slave
  assign ahb_take = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // remember a write for its data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= ahb_take & hwrite;
      if (ahb_take)
        wr_addr_q <= haddr[11:0];
    end
  end

  // configuration written by software steers both ports
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      width_q    <= WIDTH_RESET;
      par_en_q   <= PAR_EN_RESET;
      endpoint_q <= ENDPOINT_RESET;
    end
    else if (wr_pend_q && wr_addr_q == CTRL_OFFSET)
    begin
      width_q    <= hwdata[CTRL_WIDTH_LSB +: 2]; // [R1]
      par_en_q   <= hwdata[CTRL_PAR_EN];
      endpoint_q <= hwdata[CTRL_ENDPOINT];
    end
  end

  // read mux, unmapped offsets read as zero
  always_comb
  begin
    rd_value = 32'h0;
    if (haddr[11:0] == CTRL_OFFSET)
      rd_value = {28'h0, endpoint_q, par_en_q, width_q};
    else if (haddr[11:0] == STATUS_OFFSET)
      rd_value = {29'h0, rq_busy, cc_busy, internal_error};
    else if (haddr[11:0] == ABORT_CNT_OFFSET)
      rd_value = {16'h0000, cc_abort_cnt_q};
    else if (haddr[11:0] == RQ_ABORT_OFFSET)
      rd_value = {16'h0000, rq_abort_cnt_q};
  end

  // read data captured in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ahb_take && !hwrite)
      hrdata <= rd_value;
  end

  // ---------------- completion port ----------------

  // parity from sideband bits 32:1 against each data byte
  byte_parity_check u_cc_parity (
    .data       (cc_tdata),
    .parity     (completion_sideband[CC_PAR_LSB +: PAR_W]),
    .width_mode (width_q),
    .mismatch   (par_mismatch)
  );

  // mismatch only counts when checking is enabled
  assign cc_bad  = par_en_q & par_mismatch; // [R16]
  assign cc_beat = cc_tvalid & completion_ready_out[0]; // [R19]

  // sideband is looked at only on a beat
  stream_beat_stage #(.PW(DATA_W)) u_cc_stage (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .width_mode  (width_q),
    .in_valid    (cc_tvalid),
    .in_last     (cc_tlast),
    .in_keep     (cc_tkeep),
    .in_payload  (cc_tdata),
    .in_abort    (completion_sideband[CC_ABORT_BIT]),
    .in_bad      (cc_bad),
    .ready_out   (completion_ready_out),
    .out_valid   (cc_out_valid),
    .out_last    (cc_out_last),
    .out_keep    (cc_out_keep),
    .out_payload (cc_out_data),
    .out_nullify (cc_out_nullify),
    .out_ready   (cc_out_ready),
    .busy        (cc_busy),
    .abort_end   (cc_abort_end)
  ); // [R2] [R7] [R10] [R11] [R12]

  // uncorrectable internal error, cleared by reset alone
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      internal_error <= 1'b0;
    else if (cc_beat && cc_bad)
      internal_error <= 1'b1; // [R15]
  end

  // aer notice of an aborted completion in endpoint mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aer_abort_report <= 1'b0;
    else
      aer_abort_report <= cc_abort_end & endpoint_q; // [R13]
  end

  // ---------------- request port ----------------

  // separate stage, so a stalled completion never blocks requests
  stream_beat_stage #(.PW(RQ_PW)) u_rq_stage (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .width_mode  (width_q),
    .in_valid    (rq_tvalid),
    .in_last     (rq_tlast),
    .in_keep     (rq_tkeep),
    .in_payload  ({request_sideband, rq_tdata}),
    .in_abort    (1'b0),
    .in_bad      (1'b0),
    .ready_out   (request_ready_out),
    .out_valid   (rq_out_valid),
    .out_last    (rq_out_last),
    .out_keep    (rq_out_keep),
    .out_payload (rq_out_payload),
    .out_nullify (rq_out_nullify),
    .out_ready   (rq_out_ready),
    .busy        (rq_busy),
    .abort_end   (rq_abort_end)
  ); // [R17] [R18]

  assign rq_out_data     = rq_out_payload[DATA_W-1:0];
  assign rq_out_sideband = rq_out_payload[RQ_PW-1:DATA_W];

  // counts of aborted packets per port, saturating
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cc_abort_cnt_q <= COUNT_RESET;
      rq_abort_cnt_q <= COUNT_RESET;
    end
    else
    begin
      if (cc_abort_end && cc_abort_cnt_q != 16'hffff)
        cc_abort_cnt_q <= cc_abort_cnt_q + 16'h0001;
      if (rq_abort_end && rq_abort_cnt_q != 16'hffff)
        rq_abort_cnt_q <= rq_abort_cnt_q + 16'h0001;
    end
  end

  // ---------------- checks ----------------

  a_ready_bits_equal: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    (completion_ready_out == {READY_W{completion_ready_out[0]}})
    && (request_ready_out == {READY_W{request_ready_out[0]}}))
    else $error("ready bits disagree");

  a_load_needs_beat: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
    (!cc_out_valid || cc_out_ready) ##1 cc_out_valid |-> $past(cc_beat))
    else $error("completion output loaded without a beat");

  a_keep_narrow_mask: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
    cc_out_valid && width_q == WIDTH_64 && $stable(width_q) |-> cc_out_keep[7:2] == 6'h00)
    else $error("keep lanes above 64 bits forwarded");

  a_abort_nullifies: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
    cc_beat && completion_sideband[CC_ABORT_BIT] |=> cc_out_valid && cc_out_nullify)
    else $error("aborted beat not nullified");

  a_abort_stays_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
    cc_beat && !cc_tlast && (completion_sideband[CC_ABORT_BIT] || u_cc_stage.abort_q)
    |=> u_cc_stage.abort_q)
    else $error("abort lost before packet end");

  a_abort_needs_ready: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
    !cc_busy && !completion_ready_out[0] ##1 cc_beat && cc_tlast
    && !completion_sideband[CC_ABORT_BIT] && !cc_bad |=> !cc_out_nullify)
    else $error("abort taken while ready low");

  a_internal_err_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    internal_error |=> internal_error[*8])
    else $error("internal error cleared without reset");

  a_parity_disabled: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    !par_en_q && !internal_error |=> !internal_error)
    else $error("parity flagged while checking disabled");

  a_aer_endpoint: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    cc_beat && cc_tlast && completion_sideband[CC_ABORT_BIT] && endpoint_q
    ##1 $stable(endpoint_q) |=> aer_abort_report)
    else $error("endpoint abort not reported");

  a_rq_not_blocked: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
    !rq_out_valid && cc_out_valid && !cc_out_ready |=> request_ready_out[0] || rq_out_valid)
    else $error("request port stalled by completion port");

  a_ahb_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> hresp == HRESP_OKAY && hreadyout)
    else $error("ahb answer not okay and ready");
endmodule

// file: user_stream_app.sv
// user application model driving the completion and request streams
`timescale 1ns/10ps
module user_stream_app
  import ingress_pkg::*;
(
  input  wire logic                            hclk,
  input  wire logic [ingress_pkg::READY_W-1:0] cc_ready,
  input  wire logic [ingress_pkg::READY_W-1:0] rq_ready,
  output logic [ingress_pkg::DATA_W-1:0]       cc_tdata,
  output logic [ingress_pkg::CC_SB_W-1:0]      completion_sideband,
  output logic                                 cc_tlast,
  output logic [ingress_pkg::KEEP_W-1:0]       cc_tkeep,
  output logic                                 cc_tvalid,
  output logic [ingress_pkg::DATA_W-1:0]       rq_tdata,
  output logic [ingress_pkg::RQ_SB_W-1:0]      request_sideband,
  output logic                                 rq_tlast,
  output logic [ingress_pkg::KEEP_W-1:0]       rq_tkeep,
  output logic                                 rq_tvalid
);
  import ingress_pkg::*;
  // idle streams at time zero
  initial
  begin
    {cc_tdata, completion_sideband, cc_tlast, cc_tkeep, cc_tvalid} = '0;
    {rq_tdata, request_sideband, rq_tlast, rq_tkeep, rq_tvalid} = '0;
  end
  // one completion beat, held until taken
  task automatic cc_send(input logic [DATA_W-1:0] d, input logic ab, input logic bad,
                         input logic lst, input logic [KEEP_W-1:0] k);
    logic [PAR_W-1:0] p;
    for (int i = 0; i < PAR_W; i++) p[i] = ~^d[8*i +: 8]; // odd parity per byte
    cc_tdata            <= d;
    completion_sideband <= {p ^ {31'h0, bad}, ab}; // abort only with valid
    cc_tlast            <= lst;
    cc_tkeep            <= k;
    cc_tvalid           <= 1'b1; // valid kept through packet
    do @(posedge hclk); while (cc_ready[0] !== 1'b1); // beat held while stalled
  endtask
  // released lines change so stale values never look valid
  task automatic cc_idle();
    cc_tvalid           <= 1'b0;
    cc_tdata            <= ~cc_tdata;
    completion_sideband <= {~completion_sideband[32:1], 1'b0};
  endtask
  // one request beat, held until taken
  task automatic rq_send(input logic [DATA_W-1:0] d, input logic [RQ_SB_W-1:0] s,
                         input logic lst, input logic [KEEP_W-1:0] k);
    rq_tdata         <= d;
    request_sideband <= s;
    rq_tlast         <= lst;
    rq_tkeep         <= k;
    rq_tvalid        <= 1'b1;
    do @(posedge hclk); while (rq_ready[0] !== 1'b1);
  endtask
  task automatic rq_idle();
    rq_tvalid        <= 1'b0;
    rq_tdata         <= ~rq_tdata;
    request_sideband <= ~request_sideband;
  endtask
endmodule

// file: tb_top.sv
// self-checking bench for the completion and request stream ingress
`timescale 1ns/10ps
module tb_top;
  import ingress_pkg::*;
  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  logic [DATA_W-1:0]   cc_tdata, rq_tdata, cc_out_data, rq_out_data;
  logic [CC_SB_W-1:0]  completion_sideband;
  logic [RQ_SB_W-1:0]  request_sideband, rq_out_sideband;
  logic [KEEP_W-1:0]   cc_tkeep, rq_tkeep, cc_out_keep, rq_out_keep;
  logic [READY_W-1:0]  completion_ready_out, request_ready_out;
  logic                cc_tlast, cc_tvalid, rq_tlast, rq_tvalid;
  logic                cc_out_valid, cc_out_last, cc_out_nullify, cc_out_ready;
  logic                rq_out_valid, rq_out_last, rq_out_nullify, rq_out_ready;
  logic                aer_abort_report, internal_error;
  int                  miscompares = 0;
  int                  samples_checked = 0;
  int                  aer_exp = 0;
  int                  aer_seen = 0;
  logic [31:0]         seed = 32'hb5ba9ce0;
  logic                par_en = 1'b0;
  logic                ep = 1'b1;
  logic [7:0]          km = KEEP_MASK_256;
  logic [255:0]        dm = '1;
  logic [327:0]        cc_q[$];
  logic [327:0]        rq_q[$];
  logic [327:0]        cc_act, rq_act;

  pcie_cc_rq_stream_ingress dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cc_tdata(cc_tdata),
    .completion_sideband(completion_sideband), .cc_tlast(cc_tlast), .cc_tkeep(cc_tkeep),
    .cc_tvalid(cc_tvalid), .completion_ready_out(completion_ready_out), .rq_tdata(rq_tdata),
    .request_sideband(request_sideband), .rq_tlast(rq_tlast), .rq_tkeep(rq_tkeep),
    .rq_tvalid(rq_tvalid), .request_ready_out(request_ready_out),
    .cc_out_valid(cc_out_valid), .cc_out_last(cc_out_last), .cc_out_keep(cc_out_keep),
    .cc_out_data(cc_out_data), .cc_out_nullify(cc_out_nullify), .cc_out_ready(cc_out_ready),
    .rq_out_valid(rq_out_valid), .rq_out_last(rq_out_last), .rq_out_keep(rq_out_keep),
    .rq_out_data(rq_out_data), .rq_out_sideband(rq_out_sideband),
    .rq_out_nullify(rq_out_nullify), .rq_out_ready(rq_out_ready),
    .aer_abort_report(aer_abort_report), .internal_error(internal_error));

  user_stream_app u_app (.hclk(hclk), .cc_ready(completion_ready_out),
    .rq_ready(request_ready_out), .cc_tdata(cc_tdata),
    .completion_sideband(completion_sideband), .cc_tlast(cc_tlast), .cc_tkeep(cc_tkeep),
    .cc_tvalid(cc_tvalid), .rq_tdata(rq_tdata), .request_sideband(request_sideband),
    .rq_tlast(rq_tlast), .rq_tkeep(rq_tkeep), .rq_tvalid(rq_tvalid));

  // observed beats with lanes above the width masked off
  assign cc_act = {cc_out_nullify, cc_out_last, cc_out_keep, 62'h0, cc_out_data & dm};
  assign rq_act = {rq_out_nullify, rq_out_last, rq_out_keep, rq_out_sideband, rq_out_data & dm};

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check_reg(input logic [31:0] act, input logic [31:0] exp);
    samples_checked++;
    if (act !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t act %h exp %h", $time, act, exp);
    end
  endtask

  task automatic check_beat(input logic [327:0] act, input logic [327:0] exp);
    samples_checked++;
    if (act !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t act %h exp %h", $time, act, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // single ahb transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check_reg({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check_reg(r, exp);
  endtask

  task automatic set_ctrl(input logic [1:0] w, input logic p, input logic e);
    logic [31:0] r;
    par_en = p;
    ep     = e;
    km     = (w == WIDTH_64) ? KEEP_MASK_64 : (w == WIDTH_128) ? KEEP_MASK_128 : KEEP_MASK_256;
    dm     = {256{1'b1}} >> ((w == WIDTH_64) ? 192 : (w == WIDTH_128) ? 128 : 0);
    ahb(1'b1, CTRL_OFFSET, {28'h0, e, p, w}, r);
    rd_chk(CTRL_OFFSET, {28'h0, e, p, w});
  endtask

  // completion packet: abort on beat ab, bad parity on beat bad
  task automatic cc_pkt(input int n, input int ab, input int bad);
    logic [DATA_W-1:0] d;
    logic [KEEP_W-1:0] k;
    logic              st;
    st = 1'b0;
    repeat (xs() % 3) @(posedge hclk);
    @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      d  = {8{xs()}};
      k  = (i == n - 1) ? 8'hff >> (xs() % 8) : 8'hff; // contiguous
      st = st | (i == ab) | (par_en && i == bad); // sticky nullify
      cc_q.push_back({st, i == n - 1, k & km, 62'h0, d & dm});
      u_app.cc_send(d, i == ab, i == bad, i == n - 1, k);
    end
    u_app.cc_idle();
    if (ab >= 0 && ab < n && ep) aer_exp++;
  endtask

  task automatic rq_pkt(input int n);
    logic [DATA_W-1:0]  d;
    logic [KEEP_W-1:0]  k;
    logic [RQ_SB_W-1:0] s;
    repeat (xs() % 3) @(posedge hclk);
    @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      d = {8{xs()}};
      s = 62'({xs(), xs()});
      k = (i == n - 1) ? 8'hff >> (xs() % 8) : 8'hff;
      rq_q.push_back({1'b0, i == n - 1, k & km, s, d & dm});
      u_app.rq_send(d, s, i == n - 1, k);
    end
    u_app.rq_idle();
  endtask

  // wait until both ports have delivered every beat
  task automatic drain();
    for (int i = 0; i < 300 && (cc_q.size() + rq_q.size()) > 0; i++) @(posedge hclk);
    repeat (4) @(posedge hclk);
    check_reg(32'(cc_q.size() + rq_q.size()), 32'h0);
    check_reg(32'(aer_seen), 32'(aer_exp));
  endtask

  // downstream stalls at random
  always @(posedge hclk)
  begin
    cc_out_ready <= (xs() % 4) != 0;
    rq_out_ready <= (xs() % 3) != 0;
  end

  // beat monitor and ready consistency
  always @(posedge hclk)
  begin
    if (hresetn === 1'b1)
    begin
      check_reg({28'h0, completion_ready_out}, {28'h0, {4{completion_ready_out[0]}}});
      check_reg({28'h0, request_ready_out}, {28'h0, {4{request_ready_out[0]}}});
      if (cc_out_valid === 1'b1 && cc_out_ready === 1'b1)
        check_beat(cc_act, cc_q.size() ? cc_q.pop_front() : 'x);
      if (rq_out_valid === 1'b1 && rq_out_ready === 1'b1)
        check_beat(rq_act, rq_q.size() ? rq_q.pop_front() : 'x);
      if (aer_abort_report === 1'b1) aer_seen++;
    end
  end

  initial
  begin
    #400000;
    miscompares++;
    test_done();
  end

  initial
  begin
    logic [31:0] r;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize        = HSIZE_WORD;
    cc_out_ready = 1'b0;
    rq_out_ready = 1'b0;
    hresetn      = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(CTRL_OFFSET, 32'h0000_000a);
    rd_chk(STATUS_OFFSET, 32'h0);
    rd_chk(ABORT_CNT_OFFSET, 32'h0);
    rd_chk(RQ_ABORT_OFFSET, 32'h0);
    ahb(1'b1, 12'h010, 32'hffff_ffff, r);
    rd_chk(12'h010, 32'h0);
    rd_chk(CTRL_OFFSET, 32'h0000_000a);
    for (int w = 0; w < 3; w++)
    begin
      set_ctrl(2'(w), 1'b0, 1'b1);
      fork
        repeat (3) cc_pkt(1 + xs() % 4, -1, -1);
        repeat (3) rq_pkt(1 + xs() % 4);
      join
      drain();
    end
    cc_pkt(4, 1, -1); // abort raised then dropped
    cc_pkt(2, -1, -1); // sticky cleared at packet end
    cc_pkt(1, 0, -1); // single-beat abort
    drain();
    rd_chk(ABORT_CNT_OFFSET, 32'h2);
    set_ctrl(2'h2, 1'b0, 1'b0);
    cc_pkt(3, 2, -1); // no report off endpoint
    cc_pkt(2, -1, 0); // parity ignored while disabled
    drain();
    check_reg({31'h0, internal_error}, 32'h0);
    set_ctrl(2'h0, 1'b1, 1'b1);
    cc_pkt(3, -1, -1); // good parity passes
    cc_pkt(3, -1, 1);
    cc_pkt(2, -1, -1);
    drain();
    check_reg({31'h0, internal_error}, 32'h1);
    rd_chk(STATUS_OFFSET, 32'h1);
    test_done();
  end
endmodule
